// ---- hw/flash_sp_pkg.sv ----
// Constants for the flash self-programming sequencer
package flash_sp_pkg;
    // Word address width of program flash
    localparam int          ADDR_W          = 14;
    // Fixed split between the concurrent-read region and the halting region
    localparam logic [13:0] HALT_REGION_BASE = 14'h3800;
    // Boot region base per boot_size_fuses code; all lie at or above HALT_REGION_BASE
    localparam logic [13:0] BOOT_BASE_0     = 14'h3800;
    localparam logic [13:0] BOOT_BASE_1     = 14'h3C00;
    localparam logic [13:0] BOOT_BASE_2     = 14'h3E00;
    localparam logic [13:0] BOOT_BASE_3     = 14'h3F00;
    // Page size in words: low address bits select a word within a page
    localparam int          PAGE_BITS       = 6;
    // Erase or write duration
    localparam int          PROG_TIME_US    = 4;
    localparam int          CLK_MHZ         = 250;
    localparam int          PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
    localparam logic [11:0] PROG_CYCLES_M1  = 12'(PROG_CYCLES - 1);
    // Wishbone register map
    localparam logic [3:0]  CTRL_ADDR       = 4'h0;
    localparam logic [3:0]  ADDR_ADDR       = 4'h4;
    localparam logic [3:0]  LOCK_ADDR       = 4'h8;
    localparam logic [3:0]  STAT_ADDR       = 4'hC;
    // Control register bits
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          CTRL_ERASE_BIT  = 1;
    localparam int          CTRL_WRITE_BIT  = 2;
    localparam int          CTRL_REEN_BIT   = 4;
    localparam int          CTRL_BUSY_BIT   = 6;
    // Lock bit reset values: all unprogrammed
    localparam logic [1:0]  LOCK_RESET      = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_PROG} seq_state_t;
endpackage

// ---- hw/flash_self_programming_sections.sv ----
// Flash self-programming sequencer: region checks, locks, halt and busy flag
//
// Notes on behaviour
// (R1) Store from application region is refused
// (R2) Boot code may program any page
// (R3) Boot boundary comes from fuse input
// (R4) Each region has own lock bits
// (R5) Application protection uses lock set zero
// (R6) Boot protection uses lock set one
// (R7) Fixed split into concurrent/halting regions
// (R8) Concurrent region programming never halts core
// (R9) Halting region programming halts core throughout
// (R10) Boot region always inside halting region
// (R11) Busy flag high while region blocked
// (R12) Software clears busy before reading region
// (R13) Software avoids reading region while programming
// (R14) Pages matter only for erase/write
// (R15) Erase/write of concurrent region sets busy
// (R16) Re-enable write after completion clears busy
// (R17) Page-buffer load clears busy
// (R18) Refused store changes nothing at all
module flash_self_programming_sections
    import flash_sp_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Core side
    input  wire logic              store_program_op_i,
    input  wire logic [ADDR_W-1:0] exec_pc_i,
    input  wire logic [1:0]        boot_size_fuses_i,
    // Flash array side
    output logic                   core_halt_o,
    output logic                   region_busy_flag_o,
    output logic                   flash_erase_o,
    output logic                   flash_write_o,
    output logic                   page_buf_load_o,
    output logic      [ADDR_W-1:0] flash_addr_o
);
    logic              rst_meta_reg;
    logic              rst_sync_reg;
    logic              rst_n;
    logic [ADDR_W-1:0] z_addr_reg;
    logic              ctrl_enable_reg;
    logic              ctrl_erase_reg;
    logic              ctrl_write_reg;
    logic [1:0]        lock0_reg;
    logic [1:0]        lock1_reg;
    logic              region_busy_flag_reg;
    logic              core_halt_reg;
    logic              flash_erase_reg;
    logic              flash_write_reg;
    logic              page_buf_load_reg;
    logic [ADDR_W-1:0] flash_addr_reg;
    logic [11:0]       prog_cnt_reg;
    logic [31:0]       wb_dat_reg;
    logic              wb_ack_reg;
    seq_state_t        state_reg;
    logic [ADDR_W-1:0] boot_base;
    logic              pc_in_boot;
    logic              tgt_in_boot;
    logic              tgt_in_halt;
    logic              wb_req;
    logic              wb_wr;
    logic              reen_wr;
    logic              store_ok;
    logic              prog_req;
    logic              load_req;
    logic              lock_ok;
    logic              prog_start;
    logic              prog_done;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // (R3) fuse-selected boundary
    always_comb begin
        case (boot_size_fuses_i)
            2'd0:    boot_base = BOOT_BASE_0;
            2'd1:    boot_base = BOOT_BASE_1;
            2'd2:    boot_base = BOOT_BASE_2;
            default: boot_base = BOOT_BASE_3;
        endcase
    end

    assign pc_in_boot  = exec_pc_i >= boot_base;
    assign tgt_in_boot = z_addr_reg >= boot_base;
    // (R7) fixed region split
    assign tgt_in_halt = z_addr_reg >= HALT_REGION_BASE;

    // (R1) store only from boot region; (R18) otherwise nothing happens
    assign store_ok = store_program_op_i && ctrl_enable_reg && pc_in_boot
                      && state_reg == ST_IDLE;
    // (R14) page index only matters for erase and write
    assign prog_req = store_ok && (ctrl_erase_reg || ctrl_write_reg);
    assign load_req = store_ok && !ctrl_erase_reg && !ctrl_write_reg;
    // (R4) separate locks; (R5) application uses set 0; (R6) boot uses set 1
    assign lock_ok  = tgt_in_boot ? lock1_reg[0] : lock0_reg[0];
    // (R2) any page reachable from boot code
    assign prog_start = prog_req && lock_ok;
    assign prog_done  = state_reg == ST_PROG && prog_cnt_reg == '0;

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
    assign reen_wr = wb_wr && wb_adr_i == CTRL_ADDR && wb_dat_i[CTRL_REEN_BIT];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_enable_reg <= 1'b0;
            ctrl_erase_reg  <= 1'b0;
            ctrl_write_reg  <= 1'b0;
        end else if (wb_wr && wb_adr_i == CTRL_ADDR) begin
            ctrl_enable_reg <= wb_dat_i[CTRL_ENABLE_BIT];
            ctrl_erase_reg  <= wb_dat_i[CTRL_ERASE_BIT];
            ctrl_write_reg  <= wb_dat_i[CTRL_WRITE_BIT];
        end else if (store_ok || prog_done) begin
            // Enable self-clears once the operation is accepted or finished
            ctrl_enable_reg <= 1'b0;
            ctrl_erase_reg  <= 1'b0;
            ctrl_write_reg  <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            z_addr_reg <= '0;
        end else if (wb_wr && wb_adr_i == ADDR_ADDR) begin
            z_addr_reg <= wb_dat_i[ADDR_W-1:0];
        end
    end

    // Lock bits only program (1 to 0); only a reset restores them
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            lock0_reg <= LOCK_RESET;
            lock1_reg <= LOCK_RESET;
        end else if (wb_wr && wb_adr_i == LOCK_ADDR) begin
            lock0_reg <= lock0_reg & wb_dat_i[1:0];
            lock1_reg <= lock1_reg & wb_dat_i[3:2];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            prog_cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (prog_start) begin
                        state_reg    <= ST_PROG;
                        prog_cnt_reg <= PROG_CYCLES_M1;
                    end
                end
                ST_PROG: begin
                    if (prog_done) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        prog_cnt_reg <= prog_cnt_reg - 12'h001;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            flash_erase_reg   <= 1'b0;
            flash_write_reg   <= 1'b0;
            page_buf_load_reg <= 1'b0;
            flash_addr_reg    <= '0;
        end else begin
            flash_erase_reg   <= prog_start && ctrl_erase_reg;
            flash_write_reg   <= prog_start && !ctrl_erase_reg;
            page_buf_load_reg <= load_req;
            if (store_ok) begin
                flash_addr_reg <= z_addr_reg;
            end
        end
    end

    // (R9) halt for whole operation; (R8) never for concurrent region
    // (R10) boot region targets fall in the halting region by the constants
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            core_halt_reg <= 1'b0;
        end else if (prog_start) begin
            core_halt_reg <= tgt_in_halt;
        end else if (prog_done) begin
            core_halt_reg <= 1'b0;
        end
    end

    // (R15) set on start wins; (R16) re-enable clears after done; (R17) load clears
    // (R11) flag stays high while region blocked
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            region_busy_flag_reg <= 1'b0;
        end else if (prog_start && !tgt_in_halt) begin
            region_busy_flag_reg <= 1'b1;
        end else if (load_req || (reen_wr && state_reg == ST_IDLE)) begin
            region_busy_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= '0;
        end else begin
            wb_ack_reg <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    CTRL_ADDR: wb_dat_reg <= {25'h000_0000, region_busy_flag_reg, 3'h0,
                                   ctrl_write_reg, ctrl_erase_reg, ctrl_enable_reg};
                    ADDR_ADDR: wb_dat_reg <= {18'h0_0000, z_addr_reg};
                    LOCK_ADDR: wb_dat_reg <= {28'h000_0000, lock1_reg, lock0_reg};
                    STAT_ADDR: wb_dat_reg <= {30'h0000_0000, core_halt_reg,
                                   state_reg == ST_PROG};
                    default:   wb_dat_reg <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o           = wb_ack_reg;
    assign wb_dat_o           = wb_dat_reg;
    assign core_halt_o        = core_halt_reg;
    assign region_busy_flag_o = region_busy_flag_reg;
    assign flash_erase_o      = flash_erase_reg;
    assign flash_write_o      = flash_write_reg;
    assign page_buf_load_o    = page_buf_load_reg;
    assign flash_addr_o       = flash_addr_reg;

    // Assertions
    sequence s_start_conc;
        prog_start && !tgt_in_halt;
    endsequence

    a_refuse_app_store: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R1)
        store_program_op_i && !pc_in_boot |=> !flash_erase_o && !flash_write_o
            && !page_buf_load_o)
        else $error("store from application region was not refused");
    a_no_change_refused: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R18)
        store_program_op_i && !pc_in_boot && !reen_wr |=> $stable(region_busy_flag_o))
        else $error("refused store changed busy flag");
    a_busy_sets: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R15)
        s_start_conc |=> region_busy_flag_o && !core_halt_o)
        else $error("busy flag not set on concurrent region start");
    a_busy_holds: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R11)
        s_start_conc |=> region_busy_flag_o [*8])
        else $error("busy flag dropped during programming");
    a_halt_region: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R9)
        prog_start && tgt_in_halt |=> core_halt_o ##1 core_halt_o)
        else $error("core not halted for halting region");
    a_halt_ends: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R9)
        prog_done |=> !core_halt_o)
        else $error("halt outlived operation");
    a_load_clears: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R17)
        load_req |=> !region_busy_flag_o && page_buf_load_o)
        else $error("page load did not clear busy flag");
    a_reen_clears: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R16)
        reen_wr && state_reg == ST_IDLE && !prog_start |=> !region_busy_flag_o)
        else $error("re-enable did not clear busy flag");
    a_boot_in_halt: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R10)
        boot_base >= HALT_REGION_BASE)
        else $error("boot region outside halting region");
    a_lock_app: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R5)
        prog_req && !tgt_in_boot && !lock0_reg[0] |=> !flash_erase_o && !flash_write_o)
        else $error("application lock ignored");
    a_lock_boot: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R6)
        prog_req && tgt_in_boot && !lock1_reg[0] |=> !flash_erase_o && !flash_write_o)
        else $error("boot lock ignored");
    a_conc_no_halt: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R8)
        s_start_conc |=> !core_halt_o [*8])
        else $error("core halted for concurrent region");
    a_prog_any_page: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R2)
        prog_start |=> (flash_erase_o || flash_write_o) && flash_addr_o == $past(z_addr_reg))
        else $error("accepted store did not program its target page");
    a_fuse_boundary: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R3)
        store_program_op_i && exec_pc_i < boot_base |=> !flash_write_o && !page_buf_load_o)
        else $error("store below fuse boundary was accepted");
    a_busy_conc_only: assert property (@(posedge mclk_i) disable iff (!rst_n) // (R15)
        prog_start && tgt_in_halt && !region_busy_flag_o |=> !region_busy_flag_o)
        else $error("busy flag set for halting region");
endmodule

// ---- verification/flash_core_model.sv ----
// Core model: issues store-program pulses, stalls while halted
module flash_core_model
    import flash_sp_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // Bench command
    input  wire logic              go_i,
    input  wire logic [ADDR_W-1:0] pc_i,
    // Sequencer status
    input  wire logic              halt_i,
    input  wire logic              busy_i,
    // Core outputs
    output logic                   store_o,
    output logic      [ADDR_W-1:0] pc_o,
    output logic                   pend_o
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            store_o <= 1'b0;
            pend_o  <= 1'b0;
            pc_o    <= '0;
        end else begin
            store_o <= 1'b0;
            if (go_i) begin
                pend_o <= 1'b1;
                pc_o   <= pc_i;
            end
            // no fetch from blocked region, none while halted
            else if (pend_o && !halt_i && !(busy_i && pc_o < HALT_REGION_BASE)) begin
                store_o <= 1'b1;
                pend_o  <= 1'b0;
            end
        end
    end
endmodule

// ---- verification/test_flash_self_programming_sections.sv ----
// Self-checking bench for the flash self-programming sequencer
module test_flash_self_programming_sections
    import flash_sp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, go = 0;
    logic st, pend, halt, busy, er, wr, ld;
    logic [3:0] adr = '0;
    logic [31:0] dwr = '0, drd;
    logic [13:0] pc = '0, epc, fa;
    logic [1:0] fz = '0;
    int error_cnt = 0, check_count = 0, cyc_n = 0;
    int wr_n = 0, er_n = 0, ld_n = 0, halt_n = 0, h0;

    flash_self_programming_sections i_dut (.mclk_i(clk), .reset_n_i(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
        .store_program_op_i(st), .exec_pc_i(epc), .boot_size_fuses_i(fz),
        .core_halt_o(halt), .region_busy_flag_o(busy), .flash_erase_o(er),
        .flash_write_o(wr), .page_buf_load_o(ld), .flash_addr_o(fa));
    flash_core_model i_core (.mclk_i(clk), .reset_n_i(rst_n), .go_i(go),
        .pc_i(pc), .halt_i(halt), .busy_i(busy), .store_o(st), .pc_o(epc),
        .pend_o(pend));

    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        wr_n += (wr === 1'b1);
        er_n += (er === 1'b1);
        ld_n += (ld === 1'b1);
        halt_n += (halt === 1'b1);
        cyc_n++;
        if (cyc_n == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dwr <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = drd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wrr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask
    // Core executes store-program at address p, then outputs settle
    task automatic sp(input logic [13:0] p);
        go <= 1'b1;
        pc <= p;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (pend !== 1'b0) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task automatic wait_done();
        logic [31:0] q;
        q = 32'h0000_0001;
        while (q[0] !== 1'b0) wb(1'b0, STAT_ADDR, 32'h0000_0000, q);
    endtask

    task automatic t_reset();
        rdc(CTRL_ADDR, 32'h0000_0000);
        rdc(LOCK_ADDR, 32'h0000_000F);
        rdc(STAT_ADDR, 32'h0000_0000);
        rdc(4'h2, 32'h0000_0000);
    endtask
    task automatic t_region();
        wrr(ADDR_ADDR, 32'h0000_0100);
        wrr(CTRL_ADDR, 32'h0000_0005);
        sp(14'h0100);
        check(wr_n, 0);
        check(busy, 1'b0);
        fz <= 2'h3;
        sp(14'h3900);
        check(wr_n, 0);
        fz <= 2'h1;
        sp(14'h3B00);
        check(wr_n, 0);
        fz <= 2'h2;
        sp(14'h3D00);
        check(wr_n, 0);
        fz <= 2'h0;
        sp(14'h3900);
        check(wr_n, 1);
        check(fa, 14'h0100);
        check({busy, halt}, 2'b10);
        rdc(CTRL_ADDR, 32'h0000_0040);
        wait_done();
        check(busy, 1'b1);
        wrr(CTRL_ADDR, 32'h0000_0001);
        sp(14'h3900);
        check(ld_n, 1);
        check(busy, 1'b0);
    endtask
    task automatic t_reenable();
        wrr(CTRL_ADDR, 32'h0000_0005);
        sp(14'h3900);
        wrr(CTRL_ADDR, 32'h0000_0010);
        @(posedge clk);
        check(busy, 1'b1);
        wait_done();
        wrr(CTRL_ADDR, 32'h0000_0010);
        @(posedge clk);
        check(busy, 1'b0);
    endtask
    task automatic t_halt();
        wrr(ADDR_ADDR, 32'h0000_3C00);
        wrr(CTRL_ADDR, 32'h0000_0003);
        h0 = halt_n;
        sp(14'h3900);
        check(er_n, 1);
        check(busy, 1'b0);
        wait_done();
        check(halt_n - h0, PROG_CYCLES);
    endtask
    task automatic t_lock();
        wrr(LOCK_ADDR, 32'h0000_000E);
        wrr(ADDR_ADDR, 32'h0000_0100);
        wrr(CTRL_ADDR, 32'h0000_0005);
        sp(14'h3900);
        check(wr_n, 2);
        wrr(ADDR_ADDR, 32'h0000_3C00);
        wrr(CTRL_ADDR, 32'h0000_0005);
        sp(14'h3900);
        check(wr_n, 3);
        wait_done();
        wrr(LOCK_ADDR, 32'h0000_000B);
        rdc(LOCK_ADDR, 32'h0000_000A);
        wrr(CTRL_ADDR, 32'h0000_0005);
        sp(14'h3900);
        check(wr_n, 3);
        wrr(LOCK_ADDR, 32'h0000_000F);
        rdc(LOCK_ADDR, 32'h0000_000A);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_region();
        t_reenable();
        t_halt();
        t_lock();
        summarize();
    end
endmodule
